// ===== common/fie_map.vh
`ifndef FIE_MAP_VH
`define FIE_MAP_VH

// ==========================================================
// register indices, byte address is four times the index
// ==========================================================
`define FIE_IDX_BOOST       6'h0A
`define FIE_IDX_LED         6'h0C
`define FIE_IDX_SUPPLY      6'h0E
`define FIE_IDX_EVT_STATUS  6'h10
`define FIE_IDX_EVT_MASK    6'h11

// ==========================================================
// reset values
// ==========================================================
`define FIE_RST_BOOST       16'hA028
`define FIE_RST_LED         16'h00AA
`define FIE_RST_SUPPLY      16'h0000
`define FIE_RST_EVT_MASK    10'h3FF

// ==========================================================
// field layout and enable codes
// ==========================================================
`define FIE_NUM_BOOST       7
`define FIE_NUM_LED         4
`define FIE_NUM_SUPPLY      8
`define FIE_NUM_EVT         10
`define FIE_BOOST_LSB       2
`define FIE_GLOBAL_FIELD    3
`define FIE_RD_OFF          2'h0
`define FIE_RD_ON           2'h2
`define FIE_WR_DIS          2'h1
`define FIE_WR_EN           2'h3

// ==========================================================
// bus responses
// ==========================================================
`define FIE_RESP_OKAY       2'h0
`define FIE_RESP_SLVERR     2'h2

`endif

// ===== dv/fie_checker.sv
`timescale 1ns/100ps
// ==========================================
// fie_checker
// ==========================================
module fie_checker (
    input wire       aclk,
    input wire       aresetn,
    input wire       awvalid,
    input wire       awready,
    input wire       wvalid,
    input wire       wready,
    input wire [1:0] bresp,
    input wire       bvalid,
    input wire       bready,
    input wire       arvalid,
    input wire       arready,
    input wire       rvalid,
    input wire [6:0] boost_irq_enable,
    input wire [2:0] led_irq_enable,
    input wire       global_irq_enable,
    input wire       irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_rst_boost;
        $rose(aresetn) |-> boost_irq_enable == 7'h63;
    endproperty
    a_rst_boost: assert property (p_rst_boost) else $error("boost enables wrong after reset");
    property p_rst_led;
        $rose(aresetn) |-> led_irq_enable == 3'h7 && global_irq_enable;
    endproperty
    a_rst_led: assert property (p_rst_led) else $error("led enables wrong after reset");
    property p_irq_gate;
        !global_irq_enable |-> !irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without global enable");
    // enables may only move with a completed write
    property p_en_wr;
        $past(aresetn) && ($changed(boost_irq_enable) || $changed(led_irq_enable)
            || $changed(global_irq_enable)) |-> $rose(bvalid);
    endproperty
    a_en_wr: assert property (p_en_wr) else $error("enable moved without a write");
    property p_b_lat;
        awvalid && awready && wvalid && wready |-> ##2 bvalid;
    endproperty
    a_b_lat: assert property (p_b_lat) else $error("write response late");
    property p_r_lat;
        arvalid && arready |=> rvalid;
    endproperty
    a_r_lat: assert property (p_r_lat) else $error("read response late");
    property p_b_hold;
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_ar_block;
        rvalid |-> !arready;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("read accepted while busy");

    c_wr: cover property (bvalid && bready);
    c_rd: cover property (rvalid);
    c_irq: cover property ($rose(irq));
endmodule // fie_checker

bind fie_top fie_checker u_chk (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
    .bresp, .bvalid, .bready, .arvalid, .arready, .rvalid, .boost_irq_enable,
    .led_irq_enable, .global_irq_enable, .irq);

// ===== dv/fie_host_model.sv
`timescale 1ns/100ps
// ==========================================
// fie_host_model
// ==========================================
module fie_host_model (
    input  wire        aclk,
    output reg  [7:0]  awaddr = 8'h00,
    output reg         awvalid = 1'b0,
    input  wire        awready,
    output reg  [31:0] wdata = 32'h0,
    output reg  [3:0]  wstrb = 4'h0,
    output reg         wvalid = 1'b0,
    input  wire        wready,
    input  wire [1:0]  bresp,
    input  wire        bvalid,
    output reg         bready = 1'b0,
    output reg  [7:0]  araddr = 8'h00,
    output reg         arvalid = 1'b0,
    input  wire        arready,
    input  wire [31:0] rdata,
    input  wire [1:0]  rresp,
    input  wire        rvalid,
    output reg         rready = 1'b0
);
    // sampled at the falling edge: equal to what the next rising edge sees
    task wr(input [7:0] a, input [15:0] d, input [3:0] s, input lag, output [1:0] r);
        reg ta, tw, tk, tv;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {16'h0000, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= ~lag;
        tk = 1'b0;
        while (!tk) begin
            @(negedge aclk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tv = bvalid;
            tk = bvalid & bready;
            r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            // a late master raises bready only once the answer is showing
            if (tv && !tk) bready <= 1'b1;
        end
        bready <= 1'b0;
    endtask

    task rd(input [7:0] a, output [31:0] d, output [1:0] r);
        reg ta, tk;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        tk = 1'b0;
        while (!tk) begin
            @(negedge aclk);
            ta = arvalid & arready;
            tk = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask
endmodule // fie_host_model

// ===== dv/fie_top_tb.sv
`timescale 1ns/100ps
`include "fie_map.vh"
// ==========================================
// fie_top_tb
// ==========================================
module fie_top_tb;
    localparam [1:0] OK = `FIE_RESP_OKAY;
    localparam [1:0] ER = `FIE_RESP_SLVERR;
    reg         aclk = 1'b0;
    reg         aresetn = 1'b0;
    reg  [6:0]  boost_fault_evt = 7'h00;
    reg  [2:0]  led_fault_evt = 3'h0;
    reg  [7:0]  supply_fault_evt = 8'h00;
    wire [7:0]  awaddr, araddr;
    wire [31:0] wdata, rdata;
    wire [3:0]  wstrb;
    wire [1:0]  bresp, rresp;
    wire        awvalid, awready, wvalid, wready, bvalid, bready;
    wire        arvalid, arready, rvalid, rready, global_irq_enable, irq;
    wire [6:0]  boost_irq_enable;
    wire [2:0]  led_irq_enable;
    integer     bad_count = 0;
    integer     checks = 0;

    fie_top dut (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0),
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .boost_fault_evt,
        .led_fault_evt, .supply_fault_evt, .boost_irq_enable, .led_irq_enable,
        .global_irq_enable, .irq);
    fie_host_model hm (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready);

    initial begin
        forever #5 aclk = ~aclk;
    end

    task wrap_up;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task chk(input string n, input [31:0] e, input [31:0] s);
        checks = checks + 1;
        if (s !== e) begin
            bad_count = bad_count + 1;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask

    task wr(input [7:0] a, input [15:0] d, input [1:0] er);
        reg [1:0] r;
        hm.wr(a, d, 4'h3, 1'b0, r);
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask

    // lane-limited write from a master that raises bready late
    task wrs(input [7:0] a, input [15:0] d, input [3:0] s);
        reg [1:0] r;
        hm.wr(a, d, s, 1'b1, r);
        chk("bresp", {30'h0, OK}, {30'h0, r});
    endtask

    task rd(input [7:0] a, input [15:0] e, input [1:0] er);
        reg [31:0] d;
        reg [1:0]  r;
        hm.rd(a, d, r);
        chk("rdata", {16'h0000, e}, d);
        chk("rresp", {30'h0, er}, {30'h0, r});
    endtask

    // one-cycle pulse of {supply, led, boost} events
    task evt(input [17:0] v);
        @(posedge aclk);
        {supply_fault_evt, led_fault_evt, boost_fault_evt} <= v;
        @(posedge aclk);
        {supply_fault_evt, led_fault_evt, boost_fault_evt} <= 18'h0;
        @(posedge aclk);
    endtask

    task irqchk(input e);
        @(negedge aclk);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask

    initial begin
        #200000;
        bad_count = bad_count + 1;
        wrap_up;
    end

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h28, 16'hA028, OK);
        rd(8'h30, 16'h00AA, OK);
        rd(8'h38, 16'h0000, OK);
        rd(8'h44, 16'h03FF, OK);
        $display("test reset done");
        wr(8'h28, 16'h5557, OK);
        rd(8'h28, 16'h0000, OK);
        wr(8'h28, 16'hFFFF, OK);
        rd(8'h28, 16'hAAA8, OK);
        wr(8'h28, 16'h0000, OK);
        rd(8'h28, 16'hAAA8, OK);
        wr(8'h28, 16'h4000, OK);
        rd(8'h28, 16'h2AA8, OK);
        wr(8'h30, 16'hFF55, OK);
        rd(8'h30, 16'h0000, OK);
        wr(8'h30, 16'h00FF, OK);
        rd(8'h30, 16'h00AA, OK);
        $display("test codes done");
        wrs(8'h28, 16'h5555, 4'h2);
        rd(8'h28, 16'h00A8, OK);
        wrs(8'h28, 16'hFFFF, 4'h1);
        rd(8'h28, 16'h00A8, OK);
        wrs(8'h30, 16'h0055, 4'h2);
        rd(8'h30, 16'h00AA, OK);
        $display("test lanes done");
        wr(8'h3C, 16'hFFFF, ER);
        rd(8'h3C, 16'h0000, ER);
        $display("test unmapped done");
        evt({8'h80, 10'h000});
        irqchk(1'b1);
        rd(8'h38, 16'h8000, OK);
        wr(8'h38, 16'h8000, OK);
        rd(8'h38, 16'h8000, OK);
        wr(8'h38, 16'h4000, OK);
        rd(8'h38, 16'h8000, OK);
        wr(8'h38, 16'hC000, OK);
        rd(8'h38, 16'h0000, OK);
        irqchk(1'b0);
        $display("test supply done");
        evt({8'h01, 10'h000});
        wr(8'h30, 16'h0040, OK);
        irqchk(1'b0);
        wr(8'h30, 16'h00C0, OK);
        irqchk(1'b1);
        wr(8'h38, 16'h0003, OK);
        irqchk(1'b0);
        $display("test global done");
        wr(8'h28, 16'hC000, OK);
        evt({11'h000, 7'h40});
        irqchk(1'b1);
        rd(8'h40, 16'h0040, OK);
        irqchk(1'b0);
        rd(8'h40, 16'h0000, OK);
        wr(8'h44, 16'h03BF, OK);
        evt({11'h000, 7'h40});
        irqchk(1'b0);
        rd(8'h40, 16'h0040, OK);
        wr(8'h44, 16'h03FF, OK);
        wr(8'h28, 16'h4000, OK);
        evt({11'h000, 7'h40});
        irqchk(1'b0);
        rd(8'h40, 16'h0040, OK);
        $display("test events done");
        wrap_up;
    end
endmodule // fie_top_tb

// ===== verilog/fie_enable_field.v
`timescale 1ns/100ps
`include "fie_map.vh"

module fie_enable_field #(
    parameter RST_ON = 1'b1
) (
    aclk,
    aresetn,
    wr_en,
    wr_code,
    enabled,
    rd_code
);
    input  wire       aclk;
    input  wire       aresetn;
    input  wire       wr_en;
    input  wire [1:0] wr_code;
    output wire       enabled;
    output wire [1:0] rd_code;

    reg en_q;

    // ==========================================================
    // enable bit, changed only by the two dedicated write codes
    // ==========================================================
    // codes 0h and 2h leave the field alone, so a whole-register write of
    // read-back values never disturbs neighbouring sources
    always @(posedge aclk) begin
        if (!aresetn) begin
            en_q <= RST_ON;
        end else if (wr_en && wr_code == `FIE_WR_DIS) begin
            en_q <= 1'b0;
        end else if (wr_en && wr_code == `FIE_WR_EN) begin
            en_q <= 1'b1;
        end
    end

    assign enabled = en_q;
    assign rd_code = en_q ? `FIE_RD_ON : `FIE_RD_OFF;

endmodule // fie_enable_field

// ===== verilog/fie_top.v
`timescale 1ns/100ps
`include "fie_map.vh"

module fie_top (
    aclk,
    aresetn,
    awaddr,
    awprot,
    awvalid,
    awready,
    wdata,
    wstrb,
    wvalid,
    wready,
    bresp,
    bvalid,
    bready,
    araddr,
    arprot,
    arvalid,
    arready,
    rdata,
    rresp,
    rvalid,
    rready,
    boost_fault_evt,
    led_fault_evt,
    supply_fault_evt,
    boost_irq_enable,
    led_irq_enable,
    global_irq_enable,
    irq
);
    input  wire                        aclk;
    input  wire                        aresetn;
    input  wire [7:0]                  awaddr;
    input  wire [2:0]                  awprot;
    input  wire                        awvalid;
    output wire                        awready;
    input  wire [31:0]                 wdata;
    input  wire [3:0]                  wstrb;
    input  wire                        wvalid;
    output wire                        wready;
    output wire [1:0]                  bresp;
    output wire                        bvalid;
    input  wire                        bready;
    input  wire [7:0]                  araddr;
    input  wire [2:0]                  arprot;
    input  wire                        arvalid;
    output wire                        arready;
    output wire [31:0]                 rdata;
    output wire [1:0]                  rresp;
    output wire                        rvalid;
    input  wire                        rready;
    input  wire [`FIE_NUM_BOOST-1:0]   boost_fault_evt;
    input  wire [`FIE_NUM_LED-2:0]     led_fault_evt;
    input  wire [`FIE_NUM_SUPPLY-1:0]  supply_fault_evt;
    output wire [`FIE_NUM_BOOST-1:0]   boost_irq_enable;
    output wire [`FIE_NUM_LED-2:0]     led_irq_enable;
    output wire                        global_irq_enable;
    output wire                        irq;

    // ==========================================================
    // channel holding registers, status and mask state, internal nets
    // ==========================================================
    reg                        aw_hold_q;
    reg  [5:0]                 aw_idx_q;
    reg                        w_hold_q;
    reg  [15:0]                w_data_q;
    reg  [1:0]                 w_strb_q;
    reg                        bvalid_q;
    reg  [1:0]                 bresp_q;
    reg                        rvalid_q;
    reg  [1:0]                 rresp_q;
    reg  [31:0]                rdata_q;
    reg  [`FIE_NUM_SUPPLY-1:0] supply_flag_q;
    reg  [`FIE_NUM_EVT-1:0]    evt_status_q;
    reg  [`FIE_NUM_EVT-1:0]    evt_mask_q;
    reg  [15:0]                rd_word;
    reg                        rd_hit;
    wire                       wr_fire;
    wire                       wr_hit;
    wire                       rd_take;
    wire [5:0]                 rd_idx;
    wire [15:0]                boost_word;
    wire [15:0]                led_word;
    wire [15:0]                supply_word;
    wire [`FIE_NUM_LED-1:0]    led_en;
    wire [`FIE_NUM_EVT-1:0]    evt_set;
    wire [`FIE_NUM_EVT-1:0]    src_en;
    wire                       supply_clr_wr;
    wire                       evt_pend;
    wire                       supply_pend;
    wire [`FIE_NUM_SUPPLY-1:0] supply_rst;
    wire [`FIE_NUM_SUPPLY-1:0] supply_clr;
    wire [`FIE_NUM_SUPPLY-1:0] supply_flag_d;

    // protection bits carry no meaning for this block
    assign awready = ~aw_hold_q & ~bvalid_q;
    assign wready  = ~w_hold_q & ~bvalid_q;
    // address and data may arrive in either order; each half is parked until
    // the other shows up
    // one write at a time: commit once both halves are in and no answer pends
    assign wr_fire = aw_hold_q & w_hold_q & ~bvalid_q;
    // unmapped writes still get an answer, with an error code, so no master hangs
    assign wr_hit  = aw_idx_q == `FIE_IDX_BOOST || aw_idx_q == `FIE_IDX_LED ||
                     aw_idx_q == `FIE_IDX_SUPPLY || aw_idx_q == `FIE_IDX_EVT_STATUS ||
                     aw_idx_q == `FIE_IDX_EVT_MASK;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            aw_idx_q  <= 6'h00;
            w_hold_q  <= 1'b0;
            w_data_q  <= 16'h0000;
            w_strb_q  <= 2'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `FIE_RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_hold_q <= 1'b1;
                aw_idx_q  <= awaddr[7:2];
            end
            if (wvalid && wready) begin
                w_hold_q <= 1'b1;
                w_data_q <= wdata[15:0];
                w_strb_q <= wstrb[1:0];
            end
            if (wr_fire) begin
                aw_hold_q <= 1'b0;
                w_hold_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_hit ? `FIE_RESP_OKAY : `FIE_RESP_SLVERR;
            end else if (bvalid_q && bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    assign bvalid = bvalid_q;
    assign bresp  = bresp_q;

    // ==========================================================
    // boost enable register, seven two-bit fields above bit 1
    // ==========================================================
    // each field's reset state is the upper bit of its pair in the reset word;
    // the low lane strobe covers fields below bit 8, the high lane the rest
    genvar gi;
    generate
        for (gi = 0; gi < `FIE_NUM_BOOST; gi = gi + 1) begin : g_boost
            fie_enable_field #(
                .RST_ON (((`FIE_RST_BOOST >> (2*gi + `FIE_BOOST_LSB + 1)) & 16'h0001)
                         != 16'h0000)
            ) u_field (
                .aclk    (aclk),
                .aresetn (aresetn),
                .wr_en   (wr_fire && aw_idx_q == `FIE_IDX_BOOST &&
                          w_strb_q[(2*gi + `FIE_BOOST_LSB) / 8]),
                .wr_code (w_data_q[2*gi + `FIE_BOOST_LSB +: 2]),
                .enabled (boost_irq_enable[gi]),
                .rd_code (boost_word[2*gi + `FIE_BOOST_LSB +: 2])
            );
        end
    endgenerate

    // reserved low pair has no storage and reads zero
    assign boost_word[1:0] = 2'h0;

    // ==========================================================
    // led enable register, global enable in the top field
    // ==========================================================
    // all four fields sit in the low byte, so only the low lane strobe matters
    generate
        for (gi = 0; gi < `FIE_NUM_LED; gi = gi + 1) begin : g_led
            fie_enable_field #(
                .RST_ON (((`FIE_RST_LED >> (2*gi + 1)) & 16'h0001)
                         != 16'h0000)
            ) u_field (
                .aclk    (aclk),
                .aresetn (aresetn),
                .wr_en   (wr_fire && aw_idx_q == `FIE_IDX_LED && w_strb_q[0]),
                .wr_code (w_data_q[2*gi +: 2]),
                .enabled (led_en[gi]),
                .rd_code (led_word[2*gi +: 2])
            );
        end
    endgenerate

    assign led_word[15:8]    = 8'h00;
    assign led_irq_enable    = led_en[`FIE_NUM_LED-2:0];
    assign global_irq_enable = led_en[`FIE_GLOBAL_FIELD];

    // ==========================================================
    // supply fault status, flag on odd bit, clear by writing ones to both bits of the pair
    // ==========================================================
    assign supply_clr_wr = wr_fire && aw_idx_q == `FIE_IDX_SUPPLY;

    generate
        for (gi = 0; gi < `FIE_NUM_SUPPLY; gi = gi + 1) begin : g_supply
            // reset state of each flag is taken from its odd bit of the reset word
            assign supply_rst[gi]    = ((`FIE_RST_SUPPLY >> (2*gi + 1)) & 16'h0001)
                                       != 16'h0000;
            // both halves of the pair must be written as one to clear
            assign supply_clr[gi]    = supply_clr_wr && w_strb_q[gi / 4] &&
                                       w_data_q[2*gi + 1] && w_data_q[2*gi];
            // a fault arriving in the clearing cycle stays latched
            assign supply_flag_d[gi] = supply_fault_evt[gi] ? 1'b1 :
                                       (supply_clr[gi] ? 1'b0 : supply_flag_q[gi]);
            // clear bits act only at the write and read back as zero
            assign supply_word[2*gi + 1] = supply_flag_q[gi];
            assign supply_word[2*gi]     = 1'b0;
        end
    endgenerate

    always @(posedge aclk) begin
        if (!aresetn) begin
            supply_flag_q <= supply_rst;
        end else begin
            supply_flag_q <= supply_flag_d;
        end
    end

    // ==========================================================
    // boost and led fault events, read-clear status and mask
    // ==========================================================
    assign rd_take = arvalid & arready;
    assign rd_idx  = araddr[7:2];
    assign evt_set = {led_fault_evt, boost_fault_evt};
    // the mask only gates the pin; status still records masked events

    always @(posedge aclk) begin
        if (!aresetn) begin
            evt_status_q <= {`FIE_NUM_EVT{1'b0}};
            evt_mask_q   <= `FIE_RST_EVT_MASK;
        end else begin
            // set wins over the read that would clear it
            if (rd_take && rd_idx == `FIE_IDX_EVT_STATUS) begin
                evt_status_q <= evt_set;
            end else begin
                evt_status_q <= evt_status_q | evt_set;
            end
            if (wr_fire && aw_idx_q == `FIE_IDX_EVT_MASK) begin
                if (w_strb_q[0]) begin
                    evt_mask_q[7:0] <= w_data_q[7:0];
                end
                if (w_strb_q[1]) begin
                    evt_mask_q[`FIE_NUM_EVT-1:8] <= w_data_q[`FIE_NUM_EVT-1:8];
                end
            end
        end
    end

    // ==========================================================
    // interrupt output
    // ==========================================================
    // supply flags have no source enable in this block, only the global gate
    // a supply flag holds the pin up until software clears the pair
    assign src_en      = {led_irq_enable, boost_irq_enable};
    assign evt_pend    = |(evt_status_q & evt_mask_q & src_en);
    assign supply_pend = |supply_flag_q;
    assign irq         = global_irq_enable & (evt_pend | supply_pend);

    // ==========================================================
    // read channel
    // ==========================================================
    // the address is decoded in its taking cycle, so no read address is stored;
    // the price is that a new read waits until the previous answer is taken
    assign arready = ~rvalid_q;

    always @* begin
        rd_word = 16'h0000;
        rd_hit  = 1'b1;
        case (rd_idx)
            `FIE_IDX_BOOST:      rd_word = boost_word;
            `FIE_IDX_LED:        rd_word = led_word;
            `FIE_IDX_SUPPLY:     rd_word = supply_word;
            `FIE_IDX_EVT_STATUS: rd_word = {6'h00, evt_status_q};
            `FIE_IDX_EVT_MASK:   rd_word = {6'h00, evt_mask_q};
            default:             rd_hit  = 1'b0;
        endcase
    end

    // the upper half of the data bus always reads zero
    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rresp_q  <= `FIE_RESP_OKAY;
            rdata_q  <= 32'h00000000;
        end else if (rd_take) begin
            rvalid_q <= 1'b1;
            rresp_q  <= rd_hit ? `FIE_RESP_OKAY : `FIE_RESP_SLVERR;
            rdata_q  <= {16'h0000, rd_word};
        end else if (rvalid_q && rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign rvalid = rvalid_q;
    assign rresp  = rresp_q;
    assign rdata  = rdata_q;

endmodule // fie_top
